// ---- bench/cie_decode_model.sv ----
// decode stage model: ready always, or one cycle in four
`timescale 1ns/1ps
`default_nettype none
module cie_decode_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic stall,
  output var  logic outReady
);
  logic [1:0] cnt_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      {cnt_q, outReady} <= 3'h0;
    else
      {cnt_q, outReady} <= {cnt_q + 2'h1, !stall || cnt_q == 2'h3};
  end
endmodule
`default_nettype wire

// ---- bench/cie_expander_asserts.sv ----
// port assertions for the compressed instruction expander
`timescale 1ns/1ps
`default_nettype none
module cie_expander_asserts (
  // clock, reset and handshakes
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       inValid,
  input wire logic       inReady,
  input wire logic       outValid,
  input wire logic       outReady,
  // instruction fields
  input wire logic [1:0] inCompCtrl,
  input wire logic [2:0] inExecWidth,
  input wire logic [1:0] outCompCtrl,
  input wire logic [2:0] outExecWidth,
  input wire logic       outBreakpoint,
  input wire logic       outSecond
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire take = inValid && inReady && inCompCtrl == 2'h2;
  pass_unmod_a: assert property (
    outValid && !outSecond && inCompCtrl != 2'h2 |->
    outCompCtrl == inCompCtrl && outExecWidth == inExecWidth
  ) else $error("pass-through altered");
  first_half_a: assert property (
    take |-> outValid && !outSecond && outCompCtrl == 2'h0 &&
    outExecWidth == inExecWidth - 3'h1) else $error("bad first half");
  second_follows_a: assert property (
    take |=> outValid && outSecond && outCompCtrl == 2'h1
  ) else $error("no second half");
  second_width_a: assert property (
    take |=> outExecWidth == $past(inExecWidth) - 3'h1
  ) else $error("bad second width");
  break_clear_a: assert property (
    outSecond |-> !outBreakpoint) else $error("breakpoint kept");
  fetch_hold_a: assert property (
    outSecond |-> !inReady) else $error("fetch not held");
  second_stands_a: assert property (
    outSecond && !outReady |=> outSecond && $stable(outExecWidth)
  ) else $error("second half dropped");
  single_second_a: assert property (
    outSecond && outReady |=> !outSecond) else $error("extra second half");
endmodule
bind cie_expander cie_expander_asserts u_chk (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the compressed instruction expander
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clock = 1'b0, rst_b = 1'b0, stall = 1'b0, inValid = 1'b0;
  logic       inBreakpoint = 1'b0, inDstIndirect = 1'b0;
  logic       inS0Indirect = 1'b0, inS1Indirect = 1'b0;
  logic [6:0] inOpcode = 7'h01;
  logic [1:0] inCompCtrl = 2'h0, inDstHStride = 2'h1, inS0HStride = 2'h1;
  logic [1:0] inS1HStride = 2'h1, inDstFile = 2'h1, inS0File = 2'h1;
  logic [1:0] inS1File = 2'h1;
  logic [2:0] inExecWidth = 3'h3, inDstType = 3'h1, inS0Type = 3'h1;
  logic [2:0] inS1Type = 3'h1;
  logic [7:0] inDstRegNum = 8'h04, inS0RegNum = 8'h03, inS1RegNum = 8'h00;
  logic [4:0] inDstSubReg = 5'h00, inS0SubReg = 5'h00, inS1SubReg = 5'h00;
  logic [3:0] inDstAddrSub = 4'h0, inS0AddrSub = 4'h0, inS1AddrSub = 4'h0;
  logic [3:0] inS0VStride = 4'h8, inS1VStride = 4'h8;
  wire        inReady, outValid, outReady, outBreakpoint, outSecond;
  wire  [6:0] outOpcode;
  wire  [1:0] outCompCtrl;
  wire  [2:0] outExecWidth;
  wire  [7:0] outDstRegNum, outS0RegNum, outS1RegNum;
  wire  [4:0] outDstSubReg, outS0SubReg, outS1SubReg;
  wire  [3:0] outDstAddrSub, outS0AddrSub, outS1AddrSub;
  integer     err_count = 0, check_count = 0;
  always #5 clock = ~clock;
  cie_expander i_dut (.*);
  cie_decode_model i_dec (.*);
  task ck(input logic ok);
    begin
      check_count = check_count + 1;
      if (ok !== 1'b1) begin
        err_count = err_count + 1;
        $display("BAD at %0t: output mismatch", $time);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task go(input logic c, input logic [7:0] d, s0, s1,
          input logic [4:0] sb, input logic [3:0] a);
    integer n;
    begin
      inValid = 1'b1;
      #1;
      for (n = 0; n < 50 && inReady !== 1'b1; n = n + 1)
        @(negedge clock);
      ck(inReady === 1'b1);
      ck(outCompCtrl === (c ? 2'h0 : inCompCtrl));
      ck({outValid, outExecWidth} === {1'b1, inExecWidth - {2'h0, c}});
      ck({outBreakpoint, outDstRegNum} === {inBreakpoint, inDstRegNum});
      ck({outS0RegNum, outS1RegNum} === {inS0RegNum, inS1RegNum});
      ck({outOpcode, outDstSubReg} === {inOpcode, inDstSubReg});
      ck({outDstAddrSub, outS1SubReg} === {inDstAddrSub, inS1SubReg});
      ck({outS0SubReg, outS0AddrSub} === {inS0SubReg, inS0AddrSub});
      ck(outS1AddrSub === inS1AddrSub);
      @(negedge clock);
      ck(outSecond === c);
      if (c) begin
        ck({outCompCtrl, outBreakpoint, inReady} === 4'h4);
        ck({outExecWidth, outDstRegNum} === {inExecWidth - 3'h1, d});
        ck({outS0RegNum, outS1RegNum} === {s0, s1});
        ck({outS0SubReg, outS1AddrSub} === {sb, a});
        ck({outOpcode, outDstSubReg} === {inOpcode, inDstSubReg});
        ck({outDstAddrSub, outS1SubReg} === {inDstAddrSub, inS1SubReg});
        ck(outS0AddrSub === inS0AddrSub);
        for (n = 0; n < 50 && outReady !== 1'b1; n = n + 1)
          @(negedge clock);
        ck(outSecond === 1'b1);
        @(negedge clock);
        ck(outSecond === 1'b0);
      end
      $display("test done at %0t", $time);
    end
  endtask
  initial begin
    #20000;
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    inBreakpoint = 1'b1;
    go(1'b0, 8'h04, 8'h03, 8'h00, 5'h00, 4'h0);
    {inCompCtrl, inExecWidth} = {2'h2, 3'h4};
    go(1'b1, 8'h05, 8'h03, 8'h01, 5'h00, 4'h0);
    stall = 1'b1;
    {inExecWidth, inDstFile, inDstRegNum} = {3'h5, 2'h2, 8'h07};
    {inS0VStride, inS0HStride} = {4'h0, 2'h0};
    {inS0RegNum, inS0SubReg, inS1Indirect, inS1AddrSub} = {13'h0125, 5'h14};
    go(1'b1, 8'h08, 8'h09, 8'h00, 5'h05, 4'h6);
    {inOpcode, inExecWidth, inBreakpoint, inDstType} = {7'h5a, 7'h43};
    {inDstFile, inDstRegNum, inS1Indirect, inS1RegNum} = {11'h210, 8'h02};
    {inS0VStride, inS0HStride, inS0RegNum, inS0SubReg} = {6'h21, 13'h0044};
    go(1'b1, 8'h09, 8'h03, 8'h04, 5'h04, 4'h4);
    {inOpcode, inDstType, inS0Type, inS0SubReg} = {7'h01, 6'h0b, 5'h00};
    go(1'b1, 8'h09, 8'h02, 8'h03, 5'h10, 4'h4);
    inCompCtrl = 2'h0;
    go(1'b0, 8'h08, 8'h02, 8'h02, 5'h00, 4'h4);
    inValid = 1'b0;
    give_verdict;
  end
endmodule
`default_nettype wire

// ---- src/cie_expander.v ----
// compressed instruction expander top
`timescale 1ns/1ps
`default_nettype none
`include "cie_map.vh"
module cie_expander (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // fetch side
  input  wire       inValid,
  output wire       inReady,
  input  wire [6:0] inOpcode,
  input  wire [1:0] inCompCtrl,
  input  wire [2:0] inExecWidth,
  input  wire       inBreakpoint,
  input  wire [2:0] inDstType,
  input  wire [1:0] inDstHStride,
  input  wire [1:0] inDstFile,
  input  wire       inDstIndirect,
  input  wire [7:0] inDstRegNum,
  input  wire [4:0] inDstSubReg,
  input  wire [3:0] inDstAddrSub,
  input  wire [1:0] inS0File,
  input  wire       inS0Indirect,
  input  wire [7:0] inS0RegNum,
  input  wire [4:0] inS0SubReg,
  input  wire [3:0] inS0AddrSub,
  input  wire [3:0] inS0VStride,
  input  wire [1:0] inS0HStride,
  input  wire [2:0] inS0Type,
  input  wire [1:0] inS1File,
  input  wire       inS1Indirect,
  input  wire [7:0] inS1RegNum,
  input  wire [4:0] inS1SubReg,
  input  wire [3:0] inS1AddrSub,
  input  wire [3:0] inS1VStride,
  input  wire [1:0] inS1HStride,
  input  wire [2:0] inS1Type,
  // decode side
  output wire       outValid,
  input  wire       outReady,
  output wire [6:0] outOpcode,
  output wire [1:0] outCompCtrl,
  output wire [2:0] outExecWidth,
  output wire       outBreakpoint,
  output wire [7:0] outDstRegNum,
  output wire [4:0] outDstSubReg,
  output wire [3:0] outDstAddrSub,
  output wire [7:0] outS0RegNum,
  output wire [4:0] outS0SubReg,
  output wire [3:0] outS0AddrSub,
  output wire [7:0] outS1RegNum,
  output wire [4:0] outS1SubReg,
  output wire [3:0] outS1AddrSub,
  output wire       outSecond
);
  // ------------------------------------------------------------
  // second-half state
  // ------------------------------------------------------------
  reg        pend_q;
  reg [6:0]  opc_q;
  reg [2:0]  ew_q;
  reg [7:0]  dReg_q;
  reg [7:0]  s0Reg_q;
  reg [7:0]  s1Reg_q;
  reg [4:0]  dSub_q;
  reg [4:0]  s0Sub_q;
  reg [4:0]  s1Sub_q;
  reg [3:0]  dAdr_q;
  reg [3:0]  s0Adr_q;
  reg [3:0]  s1Adr_q;
  wire [7:0] dRegN;
  wire [7:0] s0RegN;
  wire [7:0] s1RegN;
  wire [4:0] dSubN;
  wire [4:0] s0SubN;
  wire [4:0] s1SubN;
  wire [3:0] dAdrN;
  wire [3:0] s0AdrN;
  wire [3:0] s1AdrN;
  wire isCompr = inCompCtrl == `CIE_CC_COMPR;
  wire mixedWord = inExecWidth == `CIE_EW_16 && inDstType == `CIE_W_DW &&
                   inDstHStride == `CIE_HS_ONE;
  wire [2:0] halfWidth = inExecWidth - 3'h1;
  // ------------------------------------------------------------
  // operand rewriters
  // ------------------------------------------------------------
  cie_operand_rewrite uDst (
    .isSrc       (1'b0),
    .regFile     (inDstFile),
    .indirect    (inDstIndirect),
    .register_number_field      (inDstRegNum),
    .subReg      (inDstSubReg),
    .addrSub     (inDstAddrSub),
    .vertical_stride     (4'h1),
    .horizontal_stride     (inDstHStride),
    .dataType    (inDstType),
    .mixedWord   (1'b0),
    .isPlaneSrc2 (1'b0),
    .regNumOut   (dRegN),
    .subRegOut   (dSubN),
    .addrSubOut  (dAdrN)
  );
  cie_operand_rewrite uS0 (
    .isSrc       (1'b1),
    .regFile     (inS0File),
    .indirect    (inS0Indirect),
    .register_number_field      (inS0RegNum),
    .subReg      (inS0SubReg),
    .addrSub     (inS0AddrSub),
    .vertical_stride     (inS0VStride),
    .horizontal_stride     (inS0HStride),
    .dataType    (inS0Type),
    .mixedWord   (mixedWord),
    .isPlaneSrc2 (1'b0),
    .regNumOut   (s0RegN),
    .subRegOut   (s0SubN),
    .addrSubOut  (s0AdrN)
  );
  cie_operand_rewrite uS1 (
    .isSrc       (1'b1),
    .regFile     (inS1File),
    .indirect    (inS1Indirect),
    .register_number_field      (inS1RegNum),
    .subReg      (inS1SubReg),
    .addrSub     (inS1AddrSub),
    .vertical_stride     (inS1VStride),
    .horizontal_stride     (inS1HStride),
    .dataType    (inS1Type),
    .mixedWord   (mixedWord),
    .isPlaneSrc2 (inOpcode == `CIE_OP_PLANE),
    .regNumOut   (s1RegN),
    .subRegOut   (s1SubN),
    .addrSubOut  (s1AdrN)
  );
  // ------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------
  // stall fetch while second half pending
  assign inReady  = outReady && !pend_q;
  assign outValid = pend_q || inValid;
  wire firstTaken = inValid && inReady && isCompr;
  wire secondTaken = pend_q && outReady;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (firstTaken) begin
      pend_q <= 1'b1;
    end else if (secondTaken) begin
      pend_q <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // second-half capture
  // ------------------------------------------------------------
  // opcode and half width
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      opc_q <= 7'h00;
      ew_q  <= 3'h0;
    end else if (firstTaken) begin
      opc_q <= inOpcode;
      ew_q  <= halfWidth;
    end
  end
  // destination second half
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dReg_q <= 8'h00;
      dSub_q <= 5'h00;
      dAdr_q <= 4'h0;
    end else if (firstTaken) begin
      dReg_q <= dRegN;
      dSub_q <= dSubN;
      dAdr_q <= dAdrN;
    end
  end
  // first source second half
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s0Reg_q <= 8'h00;
      s0Sub_q <= 5'h00;
      s0Adr_q <= 4'h0;
    end else if (firstTaken) begin
      s0Reg_q <= s0RegN;
      s0Sub_q <= s0SubN;
      s0Adr_q <= s0AdrN;
    end
  end
  // second source second half
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1Reg_q <= 8'h00;
      s1Sub_q <= 5'h00;
      s1Adr_q <= 4'h0;
    end else if (firstTaken) begin
      s1Reg_q <= s1RegN;
      s1Sub_q <= s1SubN;
      s1Adr_q <= s1AdrN;
    end
  end
  // ------------------------------------------------------------
  // output select
  // ------------------------------------------------------------
  // pass through otherwise
  assign outOpcode     = pend_q ? opc_q : inOpcode;
  assign outCompCtrl   = pend_q ? `CIE_CC_SECOND :
                         isCompr ? `CIE_CC_NORMAL : inCompCtrl;
  assign outExecWidth  = pend_q ? ew_q : isCompr ? halfWidth : inExecWidth;
  assign outBreakpoint = pend_q ? 1'b0 : inBreakpoint;
  assign outDstRegNum  = pend_q ? dReg_q : inDstRegNum;
  assign outDstSubReg  = pend_q ? dSub_q : inDstSubReg;
  assign outDstAddrSub = pend_q ? dAdr_q : inDstAddrSub;
  assign outS0RegNum   = pend_q ? s0Reg_q : inS0RegNum;
  assign outS0SubReg   = pend_q ? s0Sub_q : inS0SubReg;
  assign outS0AddrSub  = pend_q ? s0Adr_q : inS0AddrSub;
  assign outS1RegNum   = pend_q ? s1Reg_q : inS1RegNum;
  assign outS1SubReg   = pend_q ? s1Sub_q : inS1SubReg;
  assign outS1AddrSub  = pend_q ? s1Adr_q : inS1AddrSub;
  assign outSecond     = pend_q;
endmodule
`default_nettype wire

// ---- src/cie_map.vh ----
// constants and rule summary for the compressed instruction expander
// Summary of operation
// - compression code 10b emits two instructions
// - first gets 00b, second 01b, half width
// - compressed and normal instructions freely interleave
// - indirect operands allowed in compressed instructions
// - packed-word nonzero subregister kept, LSB set
// - scalar sources pass unchanged to both
// - width 16 or 32, field decremented
// - plane second source register plus two
// - general LSB set, message register plus one
// - odd general register repeats same register
// - packed word under dword stride sets subregister MSB, at width 16 only
// - indirect address subregister bit one set
// - second instruction breakpoint cleared
`ifndef CIE_MAP_VH
`define CIE_MAP_VH
`define CIE_CC_NORMAL  2'h0
`define CIE_CC_SECOND  2'h1
`define CIE_CC_COMPR   2'h2
`define CIE_RF_ARCH    2'h0
`define CIE_RF_GEN     2'h1
`define CIE_RF_MSG     2'h2
`define CIE_W_DW       3'h1
`define CIE_W_UW       3'h2
`define CIE_W_W        3'h3
`define CIE_W_UB       3'h4
`define CIE_W_B        3'h5
`define CIE_HS_ZERO    2'h0
`define CIE_HS_ONE     2'h1
`define CIE_HS_TWO     2'h2
`define CIE_VS_ZERO    4'h0
`define CIE_EW_16      3'h4
`define CIE_EW_32      3'h5
`define CIE_OP_PLANE   7'h5a
`endif

// ---- src/cie_operand_rewrite.v ----
// second-half rewrite of one register operand
`timescale 1ns/1ps
`default_nettype none
`include "cie_map.vh"
module cie_operand_rewrite (
  // operand in
  input  wire       isSrc,
  input  wire [1:0] regFile,
  input  wire       indirect,
  input  wire [7:0] register_number_field,
  input  wire [4:0] subReg,
  input  wire [3:0] addrSub,
  input  wire [3:0] vertical_stride,
  input  wire [1:0] horizontal_stride,
  input  wire [2:0] dataType,
  input  wire       mixedWord,
  input  wire       isPlaneSrc2,
  // operand out
  output reg  [7:0] regNumOut,
  output reg  [4:0] subRegOut,
  output reg  [3:0] addrSubOut
);
  wire scalar = isSrc && vertical_stride == `CIE_VS_ZERO && horizontal_stride == `CIE_HS_ZERO;
  always @* begin
    regNumOut  = register_number_field;
    subRegOut  = subReg;
    addrSubOut = addrSub;
    if (scalar) begin
      regNumOut = register_number_field;
    end else if (indirect) begin
      addrSubOut = addrSub | 4'h2;
    end else if (isPlaneSrc2) begin
      regNumOut = register_number_field + 8'h02;
    end else if (mixedWord && isSrc && horizontal_stride == `CIE_HS_ONE &&
                 (dataType == `CIE_W_W || dataType == `CIE_W_UW)) begin
      subRegOut = subReg | 5'h10;
    end else if (regFile == `CIE_RF_MSG) begin
      regNumOut = register_number_field + 8'h01;
    end else begin
      regNumOut = register_number_field | 8'h01;
    end
  end
endmodule
`default_nettype wire
